/* hdl/fsp_pkg.sv */
package fsp_pkg;

  localparam int FSP_ADDR_W = 18;

  // command codes
  localparam logic [7:0] FSP_OP_WREN     = 8'h06;
  localparam logic [7:0] FSP_OP_WRDI     = 8'h04;
  localparam logic [7:0] FSP_OP_RDSR_LO  = 8'h05;
  localparam logic [7:0] FSP_OP_RDSR_HI  = 8'h35;
  localparam logic [7:0] FSP_OP_STATUS_WRITE_CMD     = 8'h01;
  localparam logic [7:0] FSP_OP_PP       = 8'h02;
  localparam logic [7:0] FSP_OP_QPP      = 8'h32;
  localparam logic [7:0] FSP_OP_SE       = 8'h20;
  localparam logic [7:0] FSP_OP_BE32     = 8'h52;
  localparam logic [7:0] FSP_OP_BE64     = 8'hD8;
  localparam logic [7:0] FSP_OP_CE_A     = 8'h60;
  localparam logic [7:0] FSP_OP_CE_B     = 8'hC7;
  localparam logic [7:0] FSP_OP_SUSPEND  = 8'h75;
  localparam logic [7:0] FSP_OP_RESUME   = 8'h7A;
  localparam logic [7:0] FSP_OP_RST_EN   = 8'h66;
  localparam logic [7:0] FSP_OP_RST      = 8'h99;
  localparam logic [7:0] FSP_OP_DPD      = 8'hB9;
  localparam logic [7:0] FSP_OP_DPD_REL  = 8'hAB;

  // dummy cycle counts
  localparam logic [3:0] FSP_DUMMY_DUAL_0 = 4'h4;
  localparam logic [3:0] FSP_DUMMY_DUAL_1 = 4'h8;
  localparam logic [3:0] FSP_DUMMY_QUAD_0 = 4'h6;
  localparam logic [3:0] FSP_DUMMY_QUAD_1 = 4'hA;

  // bit 15 down to bit 0
  typedef struct packed {
    logic       suspend_flag;
    logic       complement_protect;
    logic       reserved;
    logic       dummy_config;
    logic [1:0] security_lock;
    logic       quad_enable;
    logic       protect_method_hi;
    logic       protect_method_lo;
    logic [4:0] block_protect;
    logic       write_enable_latch;
    logic       busy_flag;
  } fsp_status_t;

  localparam logic [15:0] FSP_STATUS_RST = 16'h0000;

  typedef struct packed {
    logic            seq;
    logic [7:0]      opcode;
    logic [2:0]      nbytes;
    logic [2:0]      bitpos;
    logic [3:0][7:0] data;
  } fsp_frame_t;

  typedef enum logic [1:0] {
    FSP_IDLE = 2'b00,
    FSP_BUSY = 2'b01,
    FSP_SUSP = 2'b11
  } fsp_state_t;

  // protected-region decode of the 256KB array
  function automatic logic fsp_prot_hit(
    input logic [FSP_ADDR_W-1:0] addr,
    input logic [4:0]            bp,
    input logic                  cmp
  );
    logic [FSP_ADDR_W-1:0] size;
    logic                  all;
    logic                  hit;
    size = '0;
    all  = 1'b0;
    if (!bp[4]) begin
      unique case (bp[1:0])
        2'b01:   size = 18'h1_0000;
        2'b10:   size = 18'h2_0000;
        2'b11:   all  = 1'b1;
        default: size = '0;
      endcase
    end else begin
      unique case (bp[2:0])
        3'b001:                 size = 18'h0_1000;
        3'b010:                 size = 18'h0_2000;
        3'b011:                 size = 18'h0_4000;
        3'b100, 3'b101, 3'b110: size = 18'h0_8000;
        3'b111:                 all  = 1'b1;
        default:                size = '0;
      endcase
    end
    hit = all | ((size != '0) &&
          (bp[3] ? (addr < size) : (addr >= (~size + 18'h0_0001))));
    return hit ^ cmp;
  endfunction

endpackage

/* hdl/fsp_link.sv */
`timescale 1ns/1ps
module fsp_link
  import fsp_pkg::*;
(
  // serial pins
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_mosi,
  input  wire logic        i_nrst,
  // quasi-static inputs, frozen by the system side during a frame
  input  wire fsp_status_t i_snap,
  input  wire logic        i_dpd,
  // frame record and serial output
  output fsp_frame_t       o_frame,
  output logic             o_miso,
  output logic             o_miso_oe
);

  logic       active_reg;
  logic [7:0] shift_reg;
  logic [7:0] byte_in;
  logic [2:0] bitpos_cur;
  logic [2:0] nb_cur;
  logic [7:0] sel_byte;
  logic       rd_cmd;

  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= 1'b1;
    end
  end

  // first edge of a frame restarts all counting
  assign bitpos_cur = active_reg ? o_frame.bitpos : 3'h0;
  assign nb_cur     = active_reg ? o_frame.nbytes : 3'h0;
  assign byte_in    = {(active_reg ? shift_reg[6:0] : 7'h00), i_mosi};

  always_ff @(posedge i_sclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_frame   <= '0;
      shift_reg <= 8'h00;
    end else begin
      shift_reg      <= byte_in;
      o_frame.bitpos <= bitpos_cur + 3'h1;
      o_frame.nbytes <= (bitpos_cur == 3'h7 && nb_cur != 3'h7) ?
                        nb_cur + 3'h1 : nb_cur;
      if (!active_reg) begin
        o_frame.seq <= ~o_frame.seq;
      end
      if (bitpos_cur == 3'h7) begin
        if (nb_cur == 3'h0) begin
          o_frame.opcode <= byte_in;
        end else if (nb_cur <= 3'h4) begin
          o_frame.data[2'(nb_cur - 3'h1)] <= byte_in;
        end
      end
    end
  end

  assign rd_cmd   = !i_dpd && (o_frame.opcode == FSP_OP_RDSR_LO ||
                               o_frame.opcode == FSP_OP_RDSR_HI);
  assign sel_byte = (o_frame.opcode == FSP_OP_RDSR_LO) ?
                    i_snap[7:0] : i_snap[15:8];

  // the selected byte repeats for as long as the read goes on
  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      o_miso    <= 1'b0;
      o_miso_oe <= 1'b0;
    end else if (active_reg && o_frame.nbytes != 3'h0 && rd_cmd) begin
      o_miso_oe <= 1'b1;
      o_miso    <= sel_byte[3'h7 - o_frame.bitpos];
    end else begin
      o_miso    <= 1'b0;
      o_miso_oe <= 1'b0;
    end
  end

endmodule

/* hdl/fsp_status_regs.sv */
`timescale 1ns/1ps
module fsp_status_regs
  import fsp_pkg::*;
#(
  parameter int STATUS_WRITE_CMD_CYCLES  = 200,
  parameter int PROG_CYCLES  = 400,
  parameter int ERASE_CYCLES = 1000,
  parameter int CHIP_CYCLES  = 4000
) (
  // system
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // serial link
  input  wire logic       i_sclk,
  input  wire logic       i_cs_n,
  input  wire logic       i_mosi,
  input  wire logic       i_wp_n,
  output logic            o_miso,
  output logic            o_miso_oe,
  // status and configuration
  output fsp_status_t     o_status,
  output logic            o_quad_enable,
  output logic [1:0]      o_sec_lock,
  output logic [3:0]      o_dummy_dual,
  output logic [3:0]      o_dummy_quad
);

  localparam int CNT_W = 16;

  fsp_frame_t             frame;
  fsp_state_t             state_reg;
  fsp_status_t            snap_reg;
  fsp_status_t            status_word;
  logic [CNT_W-1:0]       cnt_reg;
  logic                   cs_s1_reg;
  logic                   cs_s2_reg;
  logic                   cs_s3_reg;
  logic                   seq_s1_reg;
  logic                   seq_s2_reg;
  logic                   seq_seen_reg;
  logic                   wp_s1_reg;
  logic                   wp_s2_reg;
  logic                   wel_reg;
  logic [4:0]             bp_reg;
  logic                   protect_method_lo_reg;
  logic                   protect_method_hi_reg;
  logic                   qe_reg;
  logic [1:0]             lb_reg;
  logic                   dc_reg;
  logic                   cmp_reg;
  logic                   sus_reg;
  logic                   dpd_reg;
  logic                   rst_en_reg;
  logic                   op_status_write_cmd_reg;
  logic                   frame_end;
  logic                   cmd_ok;
  logic                   aligned;
  logic                   idle;
  logic                   hw_lock;
  logic                   sr_locked;
  logic                   status_write_cmd_go;
  logic                   pgm_go;
  logic                   ers_go;
  logic                   ce_go;
  logic                   ce_allowed;
  logic                   op_go;
  logic                   soft_rst;
  logic                   done;
  logic                   simple_cmd;
  logic [FSP_ADDR_W-1:0]  addr;
  logic [7:0]             op;
  logic [2:0]             nb;

  fsp_link u_link (
    .i_sclk    (i_sclk),
    .i_cs_n    (i_cs_n),
    .i_mosi    (i_mosi),
    .i_nrst    (i_nrst),
    .i_snap    (snap_reg),
    .i_dpd     (dpd_reg),
    .o_frame   (frame),
    .o_miso    (o_miso),
    .o_miso_oe (o_miso_oe)
  );

  // pin and link-level crossings
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cs_s1_reg  <= 1'b1;
      cs_s2_reg  <= 1'b1;
      cs_s3_reg  <= 1'b1;
      seq_s1_reg <= 1'b0;
      seq_s2_reg <= 1'b0;
      wp_s1_reg  <= 1'b1;
      wp_s2_reg  <= 1'b1;
    end else begin
      cs_s1_reg  <= i_cs_n;
      cs_s2_reg  <= cs_s1_reg;
      cs_s3_reg  <= cs_s2_reg;
      seq_s1_reg <= frame.seq;
      seq_s2_reg <= seq_s1_reg;
      wp_s1_reg  <= i_wp_n;
      wp_s2_reg  <= wp_s1_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      seq_seen_reg <= 1'b0;
    end else if (cs_s2_reg && !cs_s3_reg) begin
      seq_seen_reg <= seq_s2_reg;
    end
  end

  // frame record is stable once the frame has ended
  assign frame_end = cs_s2_reg && !cs_s3_reg && (seq_s2_reg != seq_seen_reg);
  assign op        = frame.opcode;
  assign nb        = frame.nbytes;
  assign aligned   = (frame.bitpos == 3'h0);
  assign addr      = {frame.data[0][FSP_ADDR_W-17:0], frame.data[1],
                      frame.data[2]};
  assign idle      = (state_reg == FSP_IDLE);
  assign cmd_ok    = frame_end && (!dpd_reg || op == FSP_OP_DPD_REL ||
                     op == FSP_OP_RST_EN || op == FSP_OP_RST);
  assign simple_cmd = cmd_ok && aligned && nb == 3'h1;

  // quad mode turns the protect pin into a data line
  assign hw_lock   = !protect_method_hi_reg && protect_method_lo_reg && !wp_s2_reg && !qe_reg;
  assign sr_locked = hw_lock || protect_method_hi_reg;

  assign status_write_cmd_go = cmd_ok && op == FSP_OP_STATUS_WRITE_CMD && aligned && nb >= 3'h2 &&
                   wel_reg && idle && !sr_locked;
  assign pgm_go  = cmd_ok && (op == FSP_OP_PP || op == FSP_OP_QPP) &&
                   aligned && nb >= 3'h5 && wel_reg && idle &&
                   !fsp_prot_hit(addr, bp_reg, cmp_reg);
  assign ers_go  = cmd_ok && (op == FSP_OP_SE || op == FSP_OP_BE32 ||
                   op == FSP_OP_BE64) && aligned && nb == 3'h4 &&
                   wel_reg && idle &&
                   !fsp_prot_hit(addr, bp_reg, cmp_reg);
  assign ce_allowed = (bp_reg[2:0] == 3'h0 && !cmp_reg) ||
                      (bp_reg[2:0] == 3'h7 && cmp_reg);
  assign ce_go   = simple_cmd && (op == FSP_OP_CE_A || op == FSP_OP_CE_B) &&
                   wel_reg && idle && ce_allowed;
  assign op_go   = status_write_cmd_go || pgm_go || ers_go || ce_go;
  assign soft_rst = simple_cmd && op == FSP_OP_RST && rst_en_reg;
  assign done    = (state_reg == FSP_BUSY) && cnt_reg == 16'h0001;

  // operation sequencing: busy, suspended, done
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_reg   <= FSP_IDLE;
      cnt_reg     <= 16'h0000;
      op_status_write_cmd_reg <= 1'b0;
    end else if (soft_rst) begin
      state_reg <= FSP_IDLE;
      cnt_reg   <= 16'h0000;
    end else begin
      unique case (state_reg)
        FSP_IDLE: begin
          if (op_go) begin
            state_reg   <= FSP_BUSY;
            op_status_write_cmd_reg <= status_write_cmd_go;
            if (status_write_cmd_go) begin
              cnt_reg <= CNT_W'(STATUS_WRITE_CMD_CYCLES);
            end else if (pgm_go) begin
              cnt_reg <= CNT_W'(PROG_CYCLES);
            end else if (ers_go) begin
              cnt_reg <= CNT_W'(ERASE_CYCLES);
            end else begin
              cnt_reg <= CNT_W'(CHIP_CYCLES);
            end
          end
        end
        FSP_BUSY: begin
          if (simple_cmd && op == FSP_OP_SUSPEND && !op_status_write_cmd_reg) begin
            state_reg <= FSP_SUSP;
          end else if (done) begin
            state_reg <= FSP_IDLE;
            cnt_reg   <= 16'h0000;
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
        FSP_SUSP: begin
          if (simple_cmd && op == FSP_OP_RESUME) begin
            state_reg <= FSP_BUSY;
          end
        end
        default: begin
          state_reg <= FSP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      wel_reg <= 1'b0;
    end else if (soft_rst || done) begin
      wel_reg <= 1'b0;
    end else if (simple_cmd && idle && op == FSP_OP_WREN) begin
      wel_reg <= 1'b1;
    end else if (simple_cmd && idle && op == FSP_OP_WRDI) begin
      wel_reg <= 1'b0;
    end
  end

  // status write: low byte first, high byte when sent
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      {protect_method_lo_reg, bp_reg} <= FSP_STATUS_RST[7:2];
      {cmp_reg, dc_reg}  <= {FSP_STATUS_RST[14], FSP_STATUS_RST[12]};
      lb_reg             <= FSP_STATUS_RST[11:10];
      {qe_reg, protect_method_hi_reg} <= FSP_STATUS_RST[9:8];
    end else if (status_write_cmd_go) begin
      {protect_method_lo_reg, bp_reg} <= frame.data[0][7:2];
      if (nb >= 3'h3) begin
        cmp_reg  <= frame.data[1][6];
        dc_reg   <= frame.data[1][4];
        lb_reg   <= lb_reg | frame.data[1][3:2];
        qe_reg   <= frame.data[1][1];
        protect_method_hi_reg <= frame.data[1][0];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      sus_reg <= 1'b0;
    end else if (soft_rst) begin
      sus_reg <= 1'b0;
    end else if (simple_cmd && op == FSP_OP_SUSPEND &&
                 state_reg == FSP_BUSY && !op_status_write_cmd_reg) begin
      sus_reg <= 1'b1;
    end else if (simple_cmd && op == FSP_OP_RESUME) begin
      sus_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      dpd_reg <= 1'b0;
    end else if (soft_rst || (simple_cmd && op == FSP_OP_DPD_REL)) begin
      dpd_reg <= 1'b0;
    end else if (simple_cmd && idle && op == FSP_OP_DPD) begin
      dpd_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rst_en_reg <= 1'b0;
    end else if (cmd_ok) begin
      rst_en_reg <= aligned && nb == 3'h1 && op == FSP_OP_RST_EN;
    end
  end

  always_comb begin
    status_word                    = fsp_status_t'(FSP_STATUS_RST);
    status_word.suspend_flag       = sus_reg;
    status_word.complement_protect = cmp_reg;
    status_word.reserved           = 1'b0;
    status_word.dummy_config       = dc_reg;
    status_word.security_lock      = lb_reg;
    status_word.quad_enable        = qe_reg;
    status_word.protect_method_hi  = protect_method_hi_reg;
    status_word.protect_method_lo  = protect_method_lo_reg;
    status_word.block_protect      = bp_reg;
    status_word.write_enable_latch = wel_reg;
    status_word.busy_flag          = (state_reg == FSP_BUSY);
  end

  // snapshot frozen while a frame runs, so the link reads a stable word
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      snap_reg <= fsp_status_t'(FSP_STATUS_RST);
    end else if (cs_s2_reg) begin
      snap_reg <= status_word;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_status      <= fsp_status_t'(FSP_STATUS_RST);
      o_quad_enable <= 1'b0;
      o_sec_lock    <= 2'h0;
      o_dummy_dual  <= FSP_DUMMY_DUAL_0;
      o_dummy_quad  <= FSP_DUMMY_QUAD_0;
    end else begin
      o_status      <= status_word;
      o_quad_enable <= qe_reg;
      o_sec_lock    <= lb_reg;
      o_dummy_dual  <= dc_reg ? FSP_DUMMY_DUAL_1 : FSP_DUMMY_DUAL_0;
      o_dummy_quad  <= dc_reg ? FSP_DUMMY_QUAD_1 : FSP_DUMMY_QUAD_0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  wel_gate_a: assert property (op_go |-> wel_reg)
    else $error("operation started without write enable");
  busy_start_a: assert property (op_go |=> o_status.busy_flag == 1'b0 ##1
                                 o_status.busy_flag)
    else $error("busy flag not raised after operation start");
  wel_clear_a: assert property (done && !soft_rst |=> !wel_reg ##1
                                !o_status.write_enable_latch)
    else $error("write enable latch kept after completion");
  bp_hold_a: assert property (!status_write_cmd_go |=> $stable(bp_reg))
    else $error("block protect changed without status write");
  hw_lock_a: assert property (!protect_method_hi_reg && protect_method_lo_reg &&
               !wp_s2_reg && !qe_reg |=> $stable(bp_reg))
    else $error("status write taken while hardware locked");
  srp_lock_a: assert property (protect_method_hi_reg |=>
                $stable({protect_method_hi_reg, protect_method_lo_reg, bp_reg}))
    else $error("status write taken under lock-down");
  chip_gate_a: assert property (ce_go |-> (!cmp_reg && bp_reg[2:0] == 3'h0)
                                || (cmp_reg && bp_reg[2:0] == 3'h7))
    else $error("chip erase started with wrong protect setting");
  prot_block_a: assert property ((pgm_go || ers_go) &&
                  !cmp_reg && bp_reg[4:2] == 3'h7 |-> addr >= 18'h0_8000)
    else $error("program or erase hit protected region");
  lock_sticky_a: assert property (lb_reg[0] |=> lb_reg[0] [*3])
    else $error("security lock bit returned to zero");
  suspend_set_a: assert property (simple_cmd && op == FSP_OP_SUSPEND &&
                  state_reg == FSP_BUSY && !op_status_write_cmd_reg && !soft_rst
                  |=> sus_reg ##1 o_status.suspend_flag)
    else $error("suspend flag not set");
  align_drop_a: assert property (frame_end && frame.bitpos != 3'h0
                                 |-> !op_go)
    else $error("unaligned frame started an operation");
  dpd_ignore_a: assert property (dpd_reg && frame_end && op == FSP_OP_WREN
                                 |=> $stable(wel_reg))
    else $error("command obeyed in deep power-down");
  dummy_sel_a: assert property (##1 o_dummy_quad ==
                  ($past(dc_reg) ? FSP_DUMMY_QUAD_1 : FSP_DUMMY_QUAD_0))
    else $error("quad dummy count does not follow config");

  status_write_c: cover property (status_write_cmd_go ##[1:1000] done);
  suspend_c: cover property (state_reg == FSP_BUSY ##1 state_reg == FSP_SUSP);
  prot_refused_c: cover property (frame_end && op == FSP_OP_SE && wel_reg &&
                                  idle && !ers_go);

endmodule

/* bench/fsp_host.sv */
`timescale 1ns/1ps
module fsp_host (
  // serial pins towards the device
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_mosi,
  // serial data from the device
  input  wire logic i_miso
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b0;
    o_mosi = 1'b0;
    // a select rise after time zero clears the link's active flag
    #2 o_cs_n = 1'b1;
  end

  // send the low n bits of tx msb first; rx keeps the last 16 bits seen
  task automatic xfer(input int n, input logic [39:0] tx,
                      output logic [15:0] rx);
    rx = '0;
    o_cs_n = 1'b0;
    #37;
    for (int i = n - 1; i >= 0; i--) begin
      o_mosi = tx[i];
      #40 o_sclk = 1'b1;
      rx = {rx[14:0], i_miso};
      #40 o_sclk = 1'b0;
    end
    // select released at the bit count asked for, whole bytes or not
    o_cs_n = 1'b1;
    // released data line must not keep the last bit
    o_mosi = ~o_mosi;
    #100;
  endtask
endmodule

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic        clk;
  logic        nrst;
  logic        wp_n;
  logic        sclk;
  logic        cs_n;
  logic        mosi;
  logic        miso;
  logic        miso_oe;
  logic        qe;
  logic [1:0]  lock;
  logic [3:0]  dd;
  logic [3:0]  dq;
  logic [15:0] st;
  logic [15:0] rx;
  int          fail_count = 0;
  int          n_tests = 0;

  // erase long enough to suspend and resume in mid-operation
  fsp_status_regs #(.STATUS_WRITE_CMD_CYCLES(20), .PROG_CYCLES(20),
    .ERASE_CYCLES(800), .CHIP_CYCLES(20)) dut (
    .i_clk(clk), .i_nrst(nrst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_mosi(mosi), .i_wp_n(wp_n), .o_miso(miso),
    .o_miso_oe(miso_oe), .o_status(st), .o_quad_enable(qe),
    .o_sec_lock(lock), .o_dummy_dual(dd), .o_dummy_quad(dq));
  // a released data line shows the inverse, so a missing enable shows
  fsp_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi),
    .i_miso(miso_oe ? miso : ~miso));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic done(input string t);
    $display("test %s done", t);
  endtask

  task automatic cmd(input logic [7:0] op);
    host.xfer(8, {32'h0000_0000, op}, rx);
  endtask

  // write enable, then status write: low byte then high byte
  task automatic status_write_cmd(input logic [15:0] v);
    cmd(8'h06);
    host.xfer(24, {16'h0000, 8'h01, v[7:0], v[15:8]}, rx);
  endtask

  task automatic erase(input logic [23:0] a);
    host.xfer(32, {8'h00, 8'h20, a}, rx);
  endtask

  // two bytes after the opcode must both carry the register
  task automatic rd(input logic [7:0] op, input logic [7:0] b);
    host.xfer(24, {16'h0000, op, 16'h0000}, rx);
    chk("read", rx, {b, b});
  endtask

  task automatic idle();
    int k = 0;
    while (st[0] !== 1'b0 && k < 1000) begin
      @(posedge clk);
      k++;
    end
    if (k == 1000) begin
      fail_count++;
      conclude();
    end
    repeat (3) @(posedge clk);
  endtask

  task automatic por();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  initial begin
    nrst = 1'b1;
    wp_n = 1'b1;
    por();
    chk("status", st, 16'h0000);
    chk("dummy", {dd, dq}, 16'h0046);
    chk("qe lock", {qe, lock}, 16'h0000);
    host.xfer(24, {16'h0000, 8'h01, 16'h7010}, rx);
    chk("no latch", st, 16'h0000);
    cmd(8'h06);
    chk("latch", st, 16'h0002);
    rd(8'h05, 8'h02);
    done("latch");
    // reserved bit written as 0
    status_write_cmd(16'h1470);
    chk("busy", st, 16'h1473);
    idle();
    chk("written", st, 16'h1470);
    chk("dummy", {dd, dq}, 16'h008A);
    chk("lock", {qe, lock}, 16'h0001);
    rd(8'h35, 8'h14);
    cmd(8'h06);
    host.xfer(20, {20'h0_0000, 8'h01, 12'h000}, rx);
    chk("cut", st, 16'h1472);
    done("write");
    erase(24'h00_7000);
    chk("prot lo", st, 16'h1472);
    erase(24'h00_8000);
    chk("erase", st, 16'h1473);
    cmd(8'h75);
    chk("susp", st, 16'h9472);
    cmd(8'h7A);
    chk("resume", st, 16'h1473);
    cmd(8'h75);
    cmd(8'h66);
    cmd(8'h99);
    chk("swreset", st, 16'h1470);
    cmd(8'h06);
    cmd(8'h60);
    chk("chip", st, 16'h1472);
    done("protect");
    status_write_cmd(16'h10F0);
    idle();
    chk("method", st, 16'h14F0);
    @(posedge clk) wp_n <= 1'b0;
    status_write_cmd(16'h1000);
    chk("wp lock", st, 16'h14F2);
    @(posedge clk) wp_n <= 1'b1;
    status_write_cmd(16'h1000);
    idle();
    chk("wp open", st, 16'h1400);
    status_write_cmd(16'h5064);
    idle();
    chk("cmp", st, 16'h5464);
    cmd(8'h06);
    erase(24'h00_1000);
    chk("cmp top", st, 16'h5466);
    erase(24'h00_0000);
    chk("cmp low", st, 16'h5467);
    idle();
    status_write_cmd(16'h5044);
    idle();
    chk("cmp fine", st, 16'h5444);
    cmd(8'h06);
    erase(24'h03_E000);
    chk("fine low", st, 16'h5446);
    erase(24'h03_F000);
    chk("fine top", st, 16'h5447);
    idle();
    status_write_cmd(16'h5004);
    idle();
    chk("cmp block", st, 16'h5404);
    cmd(8'h06);
    erase(24'h02_F000);
    chk("block low", st, 16'h5406);
    erase(24'h03_0000);
    chk("block top", st, 16'h5407);
    idle();
    done("method");
    status_write_cmd(16'h1300);
    idle();
    chk("qe st", st, 16'h1700);
    chk("qe", qe, 16'h0001);
    status_write_cmd(16'h0000);
    chk("lockdown", st, 16'h1702);
    por();
    chk("power", st, 16'h0000);
    cmd(8'hB9);
    cmd(8'h06);
    chk("dpd", st, 16'h0000);
    cmd(8'hAB);
    cmd(8'h06);
    chk("wake", st, 16'h0002);
    cmd(8'h60);
    chk("chip ok", st, 16'h0003);
    idle();
    cmd(8'h06);
    host.xfer(40, {8'h02, 24'h00_0100, 8'h5A}, rx);
    chk("program", st, 16'h0003);
    idle();
    chk("prog done", st, 16'h0000);
    cmd(8'h06);
    cmd(8'h04);
    chk("disable", st, 16'h0000);
    done("power");
    conclude();
  end
endmodule
